// ===== rtl/instr_field_decoder.sv
`timescale 1ns/1ps

// Summary of operation
// - Implicit mixed-sign multiply is on when core control bits 13:12 read 10.
// - In that mode working registers 4 and 6 are unsigned, 5 and 7 signed.
// - Operand registers alone choose any sign combination; the mode field stays put.
// - Integer multiply may write its product into accumulator A or B.
// - Accumulator select bit 0 picks A, 1 picks B.
// - Byte-mode bit 0 means word operation, 1 means byte operation.
// - Bit-position field 0000 is the LSB, 1111 the MSB.
// - Destination bit 0 writes the default working register, 1 the file register.
// - Four-bit register selects map straight onto working registers 0 to 15.
// - File address comes as 13-bit, 15-bit word with zero LSB, or 16-bit.
// - Literals are 1, 4, 6, 8, 10, 14 or 16 bits wide per format.
// - Absolute call and jump targets are 23 bits with LSB forced to zero.
// - Relative branch and call use a 16-bit offset field.
// - Double-word bit 0 means single word, 1 means double word.
// - Bit test result goes to carry when the bit is 0, zero when 1.
// - Source mode codes 000 to 101 give six modes; 11x is unused.
// - Destination mode uses the same six modes; 11x forces a device reset.
// - Offset-capable source codes 000 to 100 give direct through pre-decrement.
// - Offset-capable codes 101 are pre-increment, 11x pointer plus base register.
// - Separate fields pick dividend high word, dividend low word and shift count.
// - The 16-bit unused field of any format is ignored.
// - Accumulator, write-back and prefetch fields exist only with the DSP engine.
// - Write-back 00 direct to W13, 01 via W13 post-increment, 10 none, 11 invalid.
// - Different-register multiplicand pairs per code; 011 and 111 are invalid.
// - Prefetch code 0100 means no prefetch; 1100 gives pointer plus W12; the others give pointer and step.
module instr_field_decoder #(
    parameter bit DSP_PRESENT = 1'b1,
    parameter int INSTR_WIDTH = instr_field_pkg::INSTR_W
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [23:0] instr_word,
    input wire logic [23:0] ext_word,
    input wire instr_field_pkg::fmt_t fmt,
    input wire logic [15:0] core_control_word,
    output logic out_valid,
    output instr_field_pkg::dec_regs_t dec_regs,
    output instr_field_pkg::dec_data_t dec_data,
    output instr_field_pkg::dec_dsp_t dec_dsp,
    output logic illegal,
    output logic reset_request
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (INSTR_WIDTH != instr_field_pkg::INSTR_W) begin : g_bad_width
        $error("instr_field_decoder serves 24-bit instruction words only");
    end

    // ----------------------------------------
    // Register selects and single-bit fields
    // ----------------------------------------
    // Select fields pass through unchanged, so code n names working register n.
    wire logic [3:0] dst_reg = instr_word[instr_field_pkg::POS_DST_REG +: 4];
    wire logic [3:0] src_reg = instr_word[instr_field_pkg::POS_SRC_REG +: 4];
    wire logic [3:0] base_reg = instr_word[instr_field_pkg::POS_BASE_REG +: 4];
    wire logic [3:0] div_hi = instr_word[instr_field_pkg::POS_DIV_HI +: 4];
    wire logic [3:0] div_lo = instr_word[instr_field_pkg::POS_DIV_LO +: 4];
    wire logic [3:0] shift_cnt = instr_word[instr_field_pkg::POS_SHIFT_CNT +: 4];
    wire logic [3:0] bit_pos = instr_word[instr_field_pkg::POS_BIT_POS +: 4];
    wire logic byte_op = instr_word[instr_field_pkg::POS_BYTE];
    wire logic dword_op = instr_word[instr_field_pkg::POS_DWORD];
    wire logic to_file = instr_word[instr_field_pkg::POS_FILE_DEST];
    wire logic test_to_z = instr_word[instr_field_pkg::POS_TEST_DEST];

    // ----------------------------------------
    // Addressing modes
    // ----------------------------------------
    wire logic [2:0] src_code = instr_word[instr_field_pkg::POS_SRC_MODE +: 3];
    wire logic [2:0] dst_code = instr_word[instr_field_pkg::POS_DST_MODE +: 3];
    instr_field_pkg::addr_mode_t src_plain_mode;
    instr_field_pkg::addr_mode_t dst_plain_mode;
    instr_field_pkg::addr_mode_t src_ofs_mode;
    instr_field_pkg::addr_mode_t dst_ofs_mode;
    logic src_plain_bad;
    logic dst_plain_bad;

    addr_mode_decode #(.OFFSET_CAPABLE(1'b0)) u_src_plain (
        .code(src_code),
        .mode(src_plain_mode),
        .invalid(src_plain_bad)
    );

    addr_mode_decode #(.OFFSET_CAPABLE(1'b0)) u_dst_plain (
        .code(dst_code),
        .mode(dst_plain_mode),
        .invalid(dst_plain_bad)
    );

    addr_mode_decode #(.OFFSET_CAPABLE(1'b1)) u_src_ofs (
        .code(src_code),
        .mode(src_ofs_mode),
        .invalid()
    );

    addr_mode_decode #(.OFFSET_CAPABLE(1'b1)) u_dst_ofs (
        .code(dst_code),
        .mode(dst_ofs_mode),
        .invalid()
    );

    wire instr_field_pkg::addr_mode_t src_mode = fmt.src_ofs ? src_ofs_mode : src_plain_mode;
    wire instr_field_pkg::addr_mode_t dst_mode = fmt.dst_ofs ? dst_ofs_mode : dst_plain_mode;
    wire logic src_mode_bad = fmt.uses_src && !fmt.src_ofs && src_plain_bad;
    // A bad destination mode asks the core for a full reset and also raises illegal.
    wire logic dst_mode_bad = fmt.uses_dst && !fmt.dst_ofs && dst_plain_bad;

    // ----------------------------------------
    // Literals, file addresses and targets
    // ----------------------------------------
    // All literal widths start at one bit position; the width only sets the mask.
    wire logic [15:0] lit_raw = instr_word[instr_field_pkg::POS_LIT +: 16];
    wire logic lit_sel_bad = (fmt.lit_sel > 3'h6);
    wire logic [2:0] lit_idx = lit_sel_bad ? 3'h0 : fmt.lit_sel;
    wire logic [4:0] lit_width = instr_field_pkg::LIT_WIDTH[lit_idx];
    wire logic [16:0] lit_mask_w = (17'h0_0001 << lit_width) - 17'h0_0001;
    wire logic [15:0] literal = lit_raw & lit_mask_w[15:0];

    wire logic [15:0] fa_13 = {3'h0, instr_word[instr_field_pkg::POS_FILE +: 13]};
    wire logic [15:0] fa_15 = {instr_word[instr_field_pkg::POS_FILE +: 15], 1'b0};
    wire logic [15:0] fa_16 = instr_word[instr_field_pkg::POS_FILE +: 16];
    wire logic fa_bad = (fmt.fa_form == instr_field_pkg::FA_BAD);
    wire logic [15:0] file_addr = (fmt.fa_form == instr_field_pkg::FA_13) ? fa_13 :
                                  (fmt.fa_form == instr_field_pkg::FA_15) ? fa_15 :
                                  (fmt.fa_form == instr_field_pkg::FA_16) ? fa_16 : 16'h0000;

    // The upper target bits sit in the second program word of the instruction.
    wire logic [6:0] abs_hi = ext_word[instr_field_pkg::POS_ABS_HI +: instr_field_pkg::ABS_HI_W];
    wire logic [14:0] abs_lo = instr_word[instr_field_pkg::POS_ABS_LO +: instr_field_pkg::ABS_LO_W];
    wire logic [22:0] abs_target = {abs_hi, abs_lo, 1'b0};
    wire logic [15:0] rel_offset = instr_word[instr_field_pkg::POS_REL +: 16];

    // The bits above every used field, including the don't-care word, feed no logic.

    // ----------------------------------------
    // Multiplier operands and sign mode
    // ----------------------------------------
    wire logic [1:0] sign_mode = core_control_word[instr_field_pkg::POS_SIGN_MODE +: 2];
    wire logic implicit_mode = (sign_mode == instr_field_pkg::SIGN_MODE_IMPLICIT);
    wire logic explicit_signed = (sign_mode == instr_field_pkg::SIGN_MODE_SIGNED);
    wire logic [2:0] mul_code = instr_word[instr_field_pkg::POS_MUL +: 3];
    wire logic [1:0] same_reg = mul_code[1:0];
    wire logic mul_pair_bad = !fmt.mul_same &&
                              (mul_code == instr_field_pkg::MUL_BAD_0 ||
                               mul_code == instr_field_pkg::MUL_BAD_1);
    wire logic [1:0] mul_a = fmt.mul_same ? same_reg : instr_field_pkg::MUL_PAIR_A[mul_code];
    wire logic [1:0] mul_b = fmt.mul_same ? same_reg : instr_field_pkg::MUL_PAIR_B[mul_code];
    // Offsets 1 and 3 from W4 are W5 and W7, so bit 0 alone carries the sign.
    wire logic a_signed = implicit_mode ? mul_a[0] : explicit_signed;
    wire logic b_signed = implicit_mode ? mul_b[0] : explicit_signed;

    // ----------------------------------------
    // Accumulator and write-back
    // ----------------------------------------
    wire logic dsp_use = fmt.dsp_op || fmt.mul_to_acc;
    wire logic no_engine = !DSP_PRESENT && dsp_use;
    wire logic acc_bit = DSP_PRESENT && instr_word[instr_field_pkg::POS_ACC];
    wire instr_field_pkg::acc_t acc = acc_bit ? instr_field_pkg::ACC_B : instr_field_pkg::ACC_A;
    wire logic [1:0] wb_code = instr_word[instr_field_pkg::POS_WB +: 2];
    wire instr_field_pkg::wb_mode_t wb = (DSP_PRESENT && fmt.dsp_op) ?
                                         instr_field_pkg::wb_mode_t'(wb_code) :
                                         instr_field_pkg::WB_NONE;
    wire logic wb_bad = (wb == instr_field_pkg::WB_BAD);
    wire logic mul_to_acc = DSP_PRESENT && fmt.mul_to_acc;

    // ----------------------------------------
    // Prefetch decode, one lane per data space
    // ----------------------------------------
    instr_field_pkg::pf_t pf [0:1];

    for (genvar g = 0; g < 2; g++) begin : g_pf
        localparam int POS_OP = (g == 0) ? instr_field_pkg::POS_PF_X : instr_field_pkg::POS_PF_Y;
        localparam int POS_DST = (g == 0) ? instr_field_pkg::POS_PF_XDST : instr_field_pkg::POS_PF_YDST;
        localparam logic [3:0] BASE = (g == 0) ? instr_field_pkg::PF_X_BASE : instr_field_pkg::PF_Y_BASE;
        wire logic [3:0] op = instr_word[POS_OP +: 4];
        wire logic active = DSP_PRESENT && fmt.dsp_op && (op != instr_field_pkg::PF_NONE);
        wire logic ofs = (op == instr_field_pkg::PF_REG_OFS);
        assign pf[g].en = active;
        assign pf[g].ptr = active ? (BASE + {3'h0, op[3]}) : 4'h0;
        // The offset form reads at pointer plus W12 and leaves the pointer alone.
        assign pf[g].step = (active && !ofs) ? instr_field_pkg::PF_STEP[op[2:0]] : 4'h0;
        assign pf[g].reg_ofs = active && ofs;
        assign pf[g].dst = active ? instr_word[POS_DST +: 2] : 2'h0;
    end

    // ----------------------------------------
    // Gathering and fault summary
    // ----------------------------------------
    wire logic dsp_bad = fmt.dsp_op && (wb_bad || mul_pair_bad);
    wire logic any_bad = src_mode_bad || dst_mode_bad || lit_sel_bad ||
                         fa_bad || dsp_bad || no_engine;

    instr_field_pkg::dec_regs_t regs_next;
    instr_field_pkg::dec_data_t data_next;
    instr_field_pkg::dec_dsp_t dsp_next;

    assign regs_next = '{
        dst_reg: dst_reg,
        src_reg: src_reg,
        base_reg: base_reg,
        div_hi: div_hi,
        div_lo: div_lo,
        shift_cnt: shift_cnt,
        bit_pos: bit_pos,
        src_mode: src_mode,
        dst_mode: dst_mode,
        byte_op: byte_op,
        dword_op: dword_op,
        to_file: to_file,
        test_to_z: test_to_z
    };

    assign data_next = '{
        literal: literal,
        file_addr: file_addr,
        abs_target: abs_target,
        rel_offset: rel_offset
    };

    assign dsp_next = '{
        acc: acc,
        wb: wb,
        wb_reg: (wb == instr_field_pkg::WB_NONE) ? 4'h0 : instr_field_pkg::WB_REG,
        mul_a: mul_a,
        mul_b: mul_b,
        a_signed: a_signed,
        b_signed: b_signed,
        mul_to_acc: mul_to_acc,
        pf_x: pf[0],
        pf_y: pf[1]
    };

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    // One cycle of latency keeps every data output on a flip-flop.
    always_ff @(posedge clock) begin
        if (srst) begin
            out_valid <= 1'b0;
            illegal <= 1'b0;
            reset_request <= 1'b0;
        end else if (clk_en) begin
            out_valid <= instr_valid;
            illegal <= instr_valid && any_bad;
            reset_request <= instr_valid && dst_mode_bad;
        end
    end

    // Fields hold their last decode between instructions; out_valid says when they are fresh.
    always_ff @(posedge clock) begin
        if (srst) begin
            dec_regs <= '0;
            dec_data <= '0;
            dec_dsp <= '0;
        end else if (clk_en && instr_valid) begin
            dec_regs <= regs_next;
            dec_data <= data_next;
            dec_dsp <= dsp_next;
        end
    end

endmodule : instr_field_decoder

// ===== rtl/instr_field_pkg.sv
package instr_field_pkg;

    // ----------------------------------------
    // Word and field geometry
    // ----------------------------------------
    localparam int INSTR_W = 24;
    localparam int REG_SEL_W = 4;
    localparam int POS_DST_REG = 7;
    localparam int POS_DST_MODE = 11;
    localparam int POS_BYTE = 14;
    localparam int POS_BASE_REG = 15;
    localparam int POS_SRC_REG = 0;
    localparam int POS_SRC_MODE = 4;
    localparam int POS_FILE_DEST = 13;
    localparam int POS_BIT_POS = 12;
    localparam int POS_DWORD = 6;
    localparam int POS_TEST_DEST = 11;
    localparam int POS_DIV_HI = 11;
    localparam int POS_DIV_LO = 0;
    localparam int POS_SHIFT_CNT = 0;
    localparam int POS_LIT = 4;
    localparam int POS_FILE = 0;
    localparam int POS_REL = 0;
    localparam int POS_ABS_LO = 1;
    localparam int POS_ABS_HI = 0;
    localparam int ABS_HI_W = 7;
    localparam int ABS_LO_W = 15;
    localparam int POS_ACC = 15;
    localparam int POS_PF_XDST = 12;
    localparam int POS_PF_YDST = 10;
    localparam int POS_PF_X = 6;
    localparam int POS_PF_Y = 2;
    localparam int POS_WB = 0;
    localparam int POS_MUL = 16;
    localparam int POS_SIGN_MODE = 12;

    // ----------------------------------------
    // Code values
    // ----------------------------------------
    localparam logic [1:0] SIGN_MODE_IMPLICIT = 2'h2;
    localparam logic [1:0] SIGN_MODE_SIGNED = 2'h0;
    localparam logic [3:0] PF_NONE = 4'h4;
    localparam logic [3:0] PF_REG_OFS = 4'hc;
    localparam logic [3:0] PF_X_BASE = 4'h8;
    localparam logic [3:0] PF_Y_BASE = 4'ha;
    localparam logic [3:0] PF_OFS_REG = 4'hc;
    localparam logic [3:0] WB_REG = 4'hd;
    localparam logic [2:0] MUL_BAD_0 = 3'h3;
    localparam logic [2:0] MUL_BAD_1 = 3'h7;
    localparam logic [4:0] LIT_WIDTH [0:6] = '{5'h01, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0e, 5'h10};
    localparam logic [1:0] MUL_PAIR_A [0:7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
    localparam logic [1:0] MUL_PAIR_B [0:7] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h3, 2'h0};
    localparam logic [3:0] PF_STEP [0:7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h0, 4'ha, 4'hc, 4'he};

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ADDR_DIRECT, ADDR_IND, ADDR_POSTDEC, ADDR_POSTINC,
        ADDR_PREDEC, ADDR_PREINC, ADDR_REG_OFS, ADDR_UNUSED
    } addr_mode_t;
    typedef enum logic {ACC_A, ACC_B} acc_t;
    typedef enum logic [1:0] {WB_DIRECT, WB_POSTINC, WB_NONE, WB_BAD} wb_mode_t;
    typedef enum logic [1:0] {FA_13, FA_15, FA_16, FA_BAD} fa_form_t;
    typedef logic [2:0] lit_sel_t;

    typedef struct packed {
        lit_sel_t lit_sel;
        fa_form_t fa_form;
        logic dsp_op;
        logic mul_same;
        logic mul_to_acc;
        logic src_ofs;
        logic dst_ofs;
        logic uses_src;
        logic uses_dst;
    } fmt_t;

    typedef struct packed {
        logic [3:0] dst_reg;
        logic [3:0] src_reg;
        logic [3:0] base_reg;
        logic [3:0] div_hi;
        logic [3:0] div_lo;
        logic [3:0] shift_cnt;
        logic [3:0] bit_pos;
        addr_mode_t src_mode;
        addr_mode_t dst_mode;
        logic byte_op;
        logic dword_op;
        logic to_file;
        logic test_to_z;
    } dec_regs_t;

    typedef struct packed {
        logic [15:0] literal;
        logic [15:0] file_addr;
        logic [22:0] abs_target;
        logic [15:0] rel_offset;
    } dec_data_t;

    typedef struct packed {
        logic en;
        logic [3:0] ptr;
        logic [3:0] step;
        logic reg_ofs;
        logic [1:0] dst;
    } pf_t;

    typedef struct packed {
        acc_t acc;
        wb_mode_t wb;
        logic [3:0] wb_reg;
        logic [1:0] mul_a;
        logic [1:0] mul_b;
        logic a_signed;
        logic b_signed;
        logic mul_to_acc;
        pf_t pf_x;
        pf_t pf_y;
    } dec_dsp_t;

endpackage : instr_field_pkg

// ===== rtl/addr_mode_decode.sv
`timescale 1ns/1ps

module addr_mode_decode #(
    parameter bit OFFSET_CAPABLE = 1'b0
) (
    input wire logic [2:0] code,
    output instr_field_pkg::addr_mode_t mode,
    output logic invalid
);

    // ----------------------------------------
    // Mode map
    // ----------------------------------------
    // The two top codes share one meaning, so only code[2:1] is looked at there.
    wire logic top_code = (code[2:1] == 2'h3);

    assign mode = !top_code ? instr_field_pkg::addr_mode_t'(code) :
                  OFFSET_CAPABLE ? instr_field_pkg::ADDR_REG_OFS :
                  instr_field_pkg::ADDR_UNUSED;
    assign invalid = top_code && !OFFSET_CAPABLE;

endmodule : addr_mode_decode

// ===== test/instr_field_decoder_asserts.sv
`timescale 1ns/1ps

module instr_field_decoder_asserts #(
    parameter bit DSP_PRESENT = 1'b1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [23:0] instr_word,
    input wire logic [23:0] ext_word,
    input wire instr_field_pkg::fmt_t fmt,
    input wire logic [15:0] core_control_word,
    input wire logic out_valid,
    input wire instr_field_pkg::dec_regs_t dec_regs,
    input wire instr_field_pkg::dec_data_t dec_data,
    input wire instr_field_pkg::dec_dsp_t dec_dsp,
    input wire logic illegal,
    input wire logic reset_request
);
    // ----------------------------------------
    // Decode relations, one edge after a take
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic take;
    assign take = clk_en && instr_valid;

    reg_select_a: assert property (take |=> dec_regs.dst_reg == $past(instr_word[10:7]) &&
        dec_regs.src_reg == $past(instr_word[3:0]) && dec_regs.base_reg == $past(instr_word[18:15]))
        else $error("register select wrong");
    byte_sel_a: assert property (take |=> dec_regs.byte_op == $past(instr_word[14]))
        else $error("byte select wrong");
    abs_target_a: assert property (take |=>
        dec_data.abs_target == {$past(ext_word[6:0]), $past(instr_word[15:1]), 1'b0})
        else $error("absolute target wrong");
    rel_offset_a: assert property (take |=> dec_data.rel_offset == $past(instr_word[15:0]))
        else $error("relative offset wrong");
    dest_reset_a: assert property (take && fmt.uses_dst && !fmt.dst_ofs && instr_word[13:12] == 2'b11
        |=> reset_request && illegal) else $error("dest mode reset missing");
    mul_bad_a: assert property (take && fmt.dsp_op && !fmt.mul_same && instr_word[17:16] == 2'b11
        |=> illegal) else $error("bad multiplicand accepted");
    sign_implicit_a: assert property (take && fmt.dsp_op && !fmt.mul_same &&
        core_control_word[13:12] == 2'b10 |=> dec_dsp.a_signed == dec_dsp.mul_a[0] &&
        dec_dsp.b_signed == dec_dsp.mul_b[0]) else $error("implicit sign wrong");
    acc_sel_a: assert property (take && fmt.dsp_op |=>
        dec_dsp.acc == (DSP_PRESENT ? $past(instr_word[15]) : 1'b0)) else $error("accumulator wrong");

    cover property (out_valid && reset_request);
    cover property (out_valid && dec_dsp.a_signed != dec_dsp.b_signed);
    cover property (take ##1 take);
endmodule : instr_field_decoder_asserts

bind instr_field_decoder instr_field_decoder_asserts #(.DSP_PRESENT(DSP_PRESENT)) i_instr_field_decoder_asserts (
    .clock(clock), .srst(srst), .clk_en(clk_en), .instr_valid(instr_valid), .instr_word(instr_word),
    .ext_word(ext_word), .fmt(fmt), .core_control_word(core_control_word), .out_valid(out_valid),
    .dec_regs(dec_regs), .dec_data(dec_data), .dec_dsp(dec_dsp), .illegal(illegal),
    .reset_request(reset_request)
);

// ===== test/fetch_model.sv
`timescale 1ns/1ps

module fetch_model (
    input wire logic clock,
    output logic instr_valid,
    output logic [23:0] instr_word,
    output logic [23:0] ext_word,
    output instr_field_pkg::fmt_t fmt,
    output logic [15:0] core_control_word
);
    // ----------------------------------------
    // Fetch side
    // ----------------------------------------
    initial begin
        instr_valid = 1'b0;
        instr_word = 24'h00_0000;
        ext_word = 24'h00_0000;
        fmt = '0;
        core_control_word = 16'h0000;
    end

    // Released words are inverted so a decoder that ignores the valid flag shows changed fields.
    task automatic issue(input logic [23:0] word, input logic [23:0] ext, input instr_field_pkg::fmt_t f,
                         input logic [15:0] ccw);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word <= word;
        ext_word <= ext;
        fmt <= f;
        core_control_word <= ccw;
        @(posedge clock);
        instr_valid <= 1'b0;
        instr_word <= ~word;
        ext_word <= ~ext;
    endtask : issue
endmodule : fetch_model

// ===== test/instr_field_decoder_bench.sv
`timescale 1ns/1ps

module instr_field_decoder_bench;
    logic clock;
    logic srst;
    logic clk_en;
    logic instr_valid;
    logic [23:0] instr_word;
    logic [23:0] ext_word;
    instr_field_pkg::fmt_t fmt;
    logic [15:0] core_control_word;
    logic out_valid;
    instr_field_pkg::dec_regs_t dec_regs;
    instr_field_pkg::dec_data_t dec_data;
    instr_field_pkg::dec_dsp_t dec_dsp;
    logic illegal;
    logic reset_request;
    instr_field_pkg::fmt_t f;
    int failures = 0;
    int checked = 0;

    fetch_model i_fetch_model (.clock(clock), .instr_valid(instr_valid), .instr_word(instr_word),
        .ext_word(ext_word), .fmt(fmt), .core_control_word(core_control_word));

    instr_field_decoder i_instr_field_decoder (.clock(clock), .srst(srst), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr_word(instr_word), .ext_word(ext_word), .fmt(fmt),
        .core_control_word(core_control_word), .out_valid(out_valid), .dec_regs(dec_regs),
        .dec_data(dec_data), .dec_dsp(dec_dsp), .illegal(illegal), .reset_request(reset_request));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic final_report();
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic check_val(input logic [22:0] got, input logic [22:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check_val

    task automatic run(input logic [23:0] word, input logic [23:0] ext, input logic [15:0] ccw);
        i_fetch_model.issue(word, ext, f, ccw);
        for (int n = 0; n < 4; n++) begin
            #1;
            if (out_valid === 1'b1) begin
                return;
            end
            @(posedge clock);
        end
        failures++;
        $display("BAD %0t no answer", $time);
        final_report();
    endtask : run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        f = '0;
        run(24'h05_4783, 24'h00_0000, 16'h0000);
        check_val(23'({dec_regs.dst_reg, dec_regs.src_reg, dec_regs.base_reg}), 23'h00_0f3a);
        check_val(23'({dec_regs.byte_op, dec_regs.dword_op, dec_regs.to_file, dec_regs.test_to_z}), 23'h8);
        check_val(23'(dec_regs.bit_pos), 23'h4);
        run(24'h00_2840, 24'h00_0000, 16'h0000);
        check_val(23'({dec_regs.byte_op, dec_regs.dword_op, dec_regs.to_file, dec_regs.test_to_z}), 23'h7);
        check_val(23'({dec_regs.div_hi, dec_regs.div_lo, dec_regs.shift_cnt, dec_regs.bit_pos}), 23'h5002);
    endtask : t_regs

    task automatic t_modes(input logic ofs);
        logic [2:0] c;
        logic [2:0] m;
        logic bad;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            bad = !ofs && c[2] && c[1];
            m = (c < 3'h6) ? c : (ofs ? instr_field_pkg::ADDR_REG_OFS : instr_field_pkg::ADDR_UNUSED);
            f = '0;
            f.uses_src = 1'b1;
            f.uses_dst = 1'b1;
            f.src_ofs = ofs;
            f.dst_ofs = ofs;
            run({10'h000, c, 4'h0, c, 4'h0}, 24'h00_0000, 16'h0000);
            check_val(23'({dec_regs.src_mode, dec_regs.dst_mode}), 23'({m, m}));
            check_val(23'({illegal, reset_request}), 23'({bad, bad}));
        end
    endtask : t_modes

    task automatic t_data();
        logic [4:0] w [0:6] = '{5'h01, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0e, 5'h10};
        logic [15:0] fa [0:2] = '{16'h1fff, 16'hfffe, 16'hffff};
        f = '0;
        run(24'h00_abcd, 24'hff_ff35, 16'h0000);
        check_val(dec_data.abs_target, {7'h35, 15'h55e6, 1'b0});
        check_val(23'(dec_data.rel_offset), 23'h00_abcd);
        for (int i = 0; i < 3; i++) begin
            f.fa_form = instr_field_pkg::fa_form_t'(i);
            run(24'hff_ffff, 24'h00_0000, 16'h0000);
            check_val(23'(dec_data.file_addr), 23'(fa[i]));
        end
        f.fa_form = instr_field_pkg::FA_13;
        for (int i = 0; i < 7; i++) begin
            f.lit_sel = 3'(i);
            run(24'hff_ffff, 24'h00_0000, 16'h0000);
            check_val(23'(dec_data.literal), 23'((17'h1 << w[i]) - 17'h1));
        end
        f.lit_sel = 3'h7;
        run(24'hff_ffff, 24'h00_0000, 16'h0000);
        check_val(23'(illegal), 23'h1);
    endtask : t_data

    task automatic t_mul();
        logic [1:0] pa [0:7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
        logic [1:0] pb [0:7] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h3, 2'h0};
        logic bad;
        f = '0;
        f.dsp_op = 1'b1;
        for (int i = 0; i < 8; i++) begin
            bad = (i == 3) || (i == 7);
            run({5'h00, 3'(i), 16'h0112}, 24'h00_0000, 16'h2000);
            check_val(23'(illegal), 23'(bad));
            if (!bad) begin
                check_val(23'({dec_dsp.mul_a, dec_dsp.mul_b}), 23'({pa[i], pb[i]}));
                check_val(23'({dec_dsp.a_signed, dec_dsp.b_signed}), 23'({pa[i][0], pb[i][0]}));
            end
        end
        check_val(23'(dec_dsp.pf_x.en), 23'h0);
        run(24'h04_0112, 24'h00_0000, 16'h0000);
        check_val(23'({dec_dsp.a_signed, dec_dsp.b_signed}), 23'h3);
        run(24'h04_0112, 24'h00_0000, 16'h1000);
        check_val(23'({dec_dsp.a_signed, dec_dsp.b_signed}), 23'h0);
    endtask : t_mul

    task automatic t_dsp();
        f = '0;
        f.dsp_op = 1'b1;
        for (int k = 0; k < 4; k++) begin
            run(24'h00_0110 | 24'(k), 24'h00_0000, 16'h0000);
            check_val(23'({dec_dsp.wb, illegal}), 23'({2'(k), k == 3}));
            if (k < 2) begin
                check_val(23'(dec_dsp.wb_reg), 23'hd);
            end
        end
        run(24'h00_b672, 24'h00_0000, 16'h0000);
        check_val(23'(dec_dsp.acc), 23'h1);
        check_val(23'(dec_dsp.pf_x), 23'hc93);
        check_val(23'(dec_dsp.pf_y), 23'hd85);
        f = '0;
        f.mul_to_acc = 1'b1;
        run(24'h00_8000, 24'h00_0000, 16'h0000);
        check_val(23'({dec_dsp.mul_to_acc, illegal}), 23'h2);
    endtask : t_dsp

    task automatic t_hold();
        @(posedge clock);
        clk_en <= 1'b0;
        i_fetch_model.issue(24'h00_0000, 24'h00_0000, f, 16'h0000);
        #1;
        check_val(23'({out_valid, dec_data.rel_offset}), 23'h0_8000);
    endtask : t_hold

    initial begin
        srst = 1'b1;
        clk_en = 1'b1;
        f = '0;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        #1;
        check_val(23'({out_valid, illegal, reset_request}), 23'h0);
        check_val(23'(dec_regs === '0 && dec_data === '0 && dec_dsp === '0), 23'h1);
        t_regs();
        t_modes(1'b0);
        t_modes(1'b1);
        t_data();
        t_mul();
        t_dsp();
        t_hold();
        final_report();
    end
endmodule : instr_field_decoder_bench
